// ### rtl/ddr_pkg.sv
// Constants, register map and state encodings of the descriptor DMA run-control block.
// Assumes one 50 MHz clock and a classic Wishbone slave with 32-bit data.
// How it works
// - Setting the transmit run command puts transmit in Running and fetches a descriptor.
// - Transmit fetch starts at the list base or at the saved position.
// - Unowned transmit descriptor suspends transmit and sets the transmit unowned flag.
// - Transmit start acts only while transmit is Stopped.
// - Clearing transmit run stops after the current frame; position is saved.
// - Transmit stop acts only while Running or Suspended.
// - Second-frame overlap lets the next frame start before prior status returns.
// - Setting receive run puts receive in Running; fetch from base or saved position.
// - No owned receive descriptor suspends receive; only the first after start or after an owned one sets the receive unowned flag.
// - Receive start acts only when Stopped; stop only when Running or Suspended.
// - Clearing receive run stops after the current frame; position is saved.
// - Receive DMA stop with MAC receiver on keeps Running, no halted flag.
// - Hardware or software reset clears all interrupt enable bits.
// - Transmit done and unowned interrupts need own gate and normal summary gate.
// - Watchdog, receive halted, receive unowned, transmit halted need abnormal gate.
// - Receive done interrupt is gated by its own gate and abnormal gate.
// - Eleven-bit FIFO-full drop counter at 27:17, wrap bit 28, cleared on read.
// - Sixteen-bit no-buffer drop counter at 15:0, wrap bit 16, cleared on read.
// - Read-only current transmit buffer pointer, resets to zero.
// - Read-only current receive buffer pointer, resets to zero.
// - Transmit state field 22:20 encodes stopped, fetch, wait, read, suspend, close.
// - Receive halted flag sets whenever receive enters Stopped.
// - Transmit halted flag sets whenever transmit enters Stopped.
package ddr_pkg;
  localparam logic [7:0] ADDR_RX_BASE = 8'h0c;
  localparam logic [7:0] ADDR_TX_BASE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_CONTROL = 8'h18;
  localparam logic [7:0] ADDR_INT_EN = 8'h1c;
  localparam logic [7:0] ADDR_MISSED = 8'h20;
  localparam logic [7:0] ADDR_TX_BUF = 8'h50;
  localparam logic [7:0] ADDR_RX_BUF = 8'h54;
  // Control bits
  localparam int CTL_TX_RUN = 13;
  localparam int CTL_OVERLAP = 2;
  localparam int CTL_RX_RUN = 1;
  localparam int CTL_ONE = 21;
  // Status and enable bit positions
  localparam int ST_TX_DONE = 0;
  localparam int ST_TX_HALT = 1;
  localparam int ST_TX_UNOWN = 2;
  localparam int ST_RX_DONE = 6;
  localparam int ST_RX_UNOWN = 7;
  localparam int ST_RX_HALT = 8;
  localparam int ST_RX_OVERLEN = 9;
  localparam int ST_ABN_SUM = 15;
  localparam int ST_NRM_SUM = 16;
  localparam int ST_RX_STATE_LO = 17;
  localparam int ST_TX_STATE_LO = 20;
  localparam int MF_FULL_LO = 17;
  localparam int MF_FULL_WRAP = 28;
  localparam int MF_NOBUF_WRAP = 16;
  localparam logic [31:0] INT_EN_MASK = 32'h0001_83c7;
  localparam logic [31:0] ZERO_WORD = 32'h0;
  localparam logic [31:0] DESC_STEP = 32'h0000_0010;
  localparam logic [31:0] BASE_MASK = 32'hffff_fff0;
  localparam logic [10:0] FULL_MAX = 11'h7ff;
  localparam logic [15:0] NOBUF_MAX = 16'hffff;
  // Transmit process states, codes as software sees them
  typedef enum logic [2:0] {
    TX_STOPPED = 3'b000,
    TX_FETCH = 3'b001,
    TX_WAIT_END = 3'b010,
    TX_READ_DATA = 3'b011,
    TX_SUSPENDED = 3'b110,
    TX_CLOSE = 3'b111
  } ddr_tx_state_t;
  // Receive process states
  typedef enum logic [2:0] {
    RX_STOPPED = 3'b000,
    RX_FETCH = 3'b001,
    RX_CLOSE = 3'b101,
    RX_SUSPENDED = 3'b100,
    RX_WAIT_FRAME = 3'b011,
    RX_XFER = 3'b111
  } ddr_rx_state_t;
endpackage

// ### rtl/ddr_run_control.sv
// Run/stop control, interrupt gating, missed-frame counters and buffer pointers of a descriptor DMA.
// Assumes descriptor/buffer engines outside report ownership and frame events as one-cycle pulses.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
module ddr_run_control (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_reset_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic mac_receiver_on_i,
  input wire logic tx_desc_done_i,
  input wire logic tx_desc_owned_i,
  input wire logic tx_data_done_i,
  input wire logic tx_status_done_i,
  input wire logic [31:0] tx_buf_addr_i,
  input wire logic rx_desc_done_i,
  input wire logic rx_desc_owned_i,
  input wire logic rx_frame_start_i,
  input wire logic rx_frame_end_i,
  input wire logic [31:0] rx_buf_addr_i,
  input wire logic rx_overlength_i,
  input wire logic fifo_full_drop_i,
  input wire logic no_buffer_drop_i,
  output logic [31:0] tx_desc_addr_o,
  output logic [31:0] rx_desc_addr_o,
  output logic tx_fetch_o,
  output logic rx_fetch_o,
  output logic second_frame_overlap_o,
  output logic required_one_bit_o,
  output logic normal_irq_o,
  output logic abnormal_irq_o
);
  import ddr_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] control;
    logic [31:0] int_en;
    logic [31:0] status;
    logic [31:0] tx_base;
    logic [31:0] rx_base;
    logic [31:0] tx_pos;
    logic [31:0] rx_pos;
    logic [31:0] tx_buf;
    logic [31:0] rx_buf;
    logic [10:0] full_cnt;
    logic full_wrap;
    logic [15:0] nobuf_cnt;
    logic nobuf_wrap;
    logic tx_pending;
    ddr_tx_state_t tx_st;
    ddr_rx_state_t rx_st;
    logic rx_unown_seen;
  } ddr_state_t;

  ddr_state_t cur;
  ddr_state_t next_cur;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Saturation-free counter step that reports a wrap
  function automatic logic [16:0] count_step(input logic [15:0] val, input logic [15:0] max);
    return (val == max) ? {1'b1, 16'h0} : {1'b0, val + 16'h1};
  endfunction

  logic req;
  logic wr;
  logic rd;
  logic [7:0] adr;
  logic [31:0] wmerged;
  logic [31:0] status_word;
  logic [31:0] missed_word;
  logic nrm_sum;
  logic abn_sum;
  logic [16:0] full_step;
  logic [16:0] nobuf_step;

  // Request decode; one access per handshake, ack withdrawn the cycle after
  assign req = wb_cyc_i && wb_stb_i && !cur.ack;
  assign wr = req && wb_we_i;
  assign rd = req && !wb_we_i;
  assign adr = wb_adr_i[7:0];

  // Summaries: receive done rides on the abnormal gate as the hardware does
  assign nrm_sum = cur.int_en[ST_NRM_SUM] && |(cur.status[ST_TX_DONE] & cur.int_en[ST_TX_DONE]
    | cur.status[ST_TX_UNOWN] & cur.int_en[ST_TX_UNOWN]);
  assign abn_sum = cur.int_en[ST_ABN_SUM] && |(cur.status[ST_TX_HALT] & cur.int_en[ST_TX_HALT]
    | cur.status[ST_RX_UNOWN] & cur.int_en[ST_RX_UNOWN]
    | cur.status[ST_RX_HALT] & cur.int_en[ST_RX_HALT]
    | cur.status[ST_RX_OVERLEN] & cur.int_en[ST_RX_OVERLEN]
    | cur.status[ST_RX_DONE] & cur.int_en[ST_RX_DONE]);

  always_comb begin
    status_word = cur.status;
    status_word[ST_NRM_SUM] = nrm_sum;
    status_word[ST_ABN_SUM] = abn_sum;
    status_word[ST_TX_STATE_LO +: 3] = cur.tx_st;
    status_word[ST_RX_STATE_LO +: 3] = cur.rx_st;
    missed_word = ZERO_WORD;
    missed_word[MF_FULL_WRAP] = cur.full_wrap;
    missed_word[MF_FULL_LO +: 11] = cur.full_cnt;
    missed_word[MF_NOBUF_WRAP] = cur.nobuf_wrap;
    missed_word[15:0] = cur.nobuf_cnt;
  end

  assign full_step = count_step({5'h0, cur.full_cnt}, {5'h0, FULL_MAX});
  assign nobuf_step = count_step(cur.nobuf_cnt, NOBUF_MAX);

  // Next-state logic for bus, run control and counters
  always_comb begin
    logic tx_run_now;
    logic rx_run_now;
    logic tx_cmd_stop;
    logic rx_cmd_stop;
    logic tx_cmd_start;
    logic rx_cmd_start;
    next_cur = cur;
    next_cur.ack = req;
    wmerged = lane_merge(cur.control, wb_dat_i, wb_sel_i);
    tx_run_now = cur.control[CTL_TX_RUN];
    rx_run_now = cur.control[CTL_RX_RUN];
    tx_cmd_start = 1'b0;
    rx_cmd_start = 1'b0;
    tx_cmd_stop = 1'b0;
    rx_cmd_stop = 1'b0;
    // Register writes
    if (wr) begin
      case (adr)
        ADDR_CONTROL: begin
          next_cur.control = wmerged;
          tx_cmd_start = wmerged[CTL_TX_RUN] && !tx_run_now;
          tx_cmd_stop = !wmerged[CTL_TX_RUN] && tx_run_now;
          rx_cmd_start = wmerged[CTL_RX_RUN] && !rx_run_now;
          rx_cmd_stop = !wmerged[CTL_RX_RUN] && rx_run_now;
        end
        ADDR_INT_EN: next_cur.int_en = lane_merge(cur.int_en, wb_dat_i, wb_sel_i) & INT_EN_MASK;
        // Base writes only count while stopped; otherwise the saved position would be lost
        ADDR_TX_BASE: begin
          if (cur.tx_st == TX_STOPPED) next_cur.tx_base = lane_merge(cur.tx_base, wb_dat_i, wb_sel_i) & BASE_MASK;
        end
        ADDR_RX_BASE: begin
          if (cur.rx_st == RX_STOPPED) next_cur.rx_base = lane_merge(cur.rx_base, wb_dat_i, wb_sel_i) & BASE_MASK;
        end
        // Write one to clear; events below set again, so a set in the same cycle wins
        ADDR_STATUS: next_cur.status = cur.status & ~lane_merge(ZERO_WORD, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
    // Register reads, with clear-on-read of the missed-frame word
    if (rd) begin
      case (adr)
        ADDR_CONTROL: next_cur.rdata = cur.control;
        ADDR_INT_EN: next_cur.rdata = cur.int_en;
        ADDR_STATUS: next_cur.rdata = status_word;
        ADDR_TX_BASE: next_cur.rdata = cur.tx_base;
        ADDR_RX_BASE: next_cur.rdata = cur.rx_base;
        ADDR_MISSED: begin
          next_cur.rdata = missed_word;
          next_cur.full_cnt = 11'h0;
          next_cur.full_wrap = 1'b0;
          next_cur.nobuf_cnt = 16'h0;
          next_cur.nobuf_wrap = 1'b0;
        end
        ADDR_TX_BUF: next_cur.rdata = cur.tx_buf;
        ADDR_RX_BUF: next_cur.rdata = cur.rx_buf;
        default: next_cur.rdata = ZERO_WORD;
      endcase
    end
    // Drop counters; an event in the read cycle is counted from zero, so none is lost
    if (fifo_full_drop_i) begin
      next_cur.full_cnt = rd && adr == ADDR_MISSED ? 11'h1 : full_step[10:0];
      if (full_step[16] && !(rd && adr == ADDR_MISSED)) next_cur.full_wrap = 1'b1;
    end
    if (no_buffer_drop_i) begin
      next_cur.nobuf_cnt = rd && adr == ADDR_MISSED ? 16'h1 : nobuf_step[15:0];
      if (nobuf_step[16] && !(rd && adr == ADDR_MISSED)) next_cur.nobuf_wrap = 1'b1;
    end
    // Transmit process
    if (tx_cmd_stop && cur.tx_st != TX_STOPPED) next_cur.tx_pending = 1'b1;
    case (cur.tx_st)
      TX_STOPPED: begin
        if (tx_cmd_start) begin
          next_cur.tx_st = TX_FETCH;
        end
      end
      TX_FETCH: begin
        if (tx_desc_done_i) begin
          if (!tx_desc_owned_i) begin
            next_cur.tx_st = TX_SUSPENDED;
            next_cur.status[ST_TX_UNOWN] = 1'b1;
          end else begin
            next_cur.tx_st = TX_READ_DATA;
          end
        end
      end
      TX_READ_DATA: begin
        next_cur.tx_buf = tx_buf_addr_i;
        if (tx_data_done_i) begin
          next_cur.tx_st = cur.control[CTL_OVERLAP] ? TX_CLOSE : TX_WAIT_END;
        end
      end
      TX_WAIT_END: if (tx_status_done_i) next_cur.tx_st = TX_CLOSE;
      TX_CLOSE: begin
        next_cur.tx_pos = cur.tx_pos + DESC_STEP;
        next_cur.status[ST_TX_DONE] = 1'b1;
        next_cur.tx_st = TX_FETCH;
      end
      TX_SUSPENDED: if (tx_cmd_stop) next_cur.tx_pending = 1'b1;
      default: next_cur.tx_st = TX_STOPPED;
    endcase
    // Stop once no frame is in progress
    if ((cur.tx_pending || (tx_cmd_stop && cur.tx_st == TX_SUSPENDED)) &&
        (cur.tx_st == TX_FETCH || cur.tx_st == TX_SUSPENDED)) begin
      next_cur.tx_st = TX_STOPPED;
      next_cur.tx_pending = 1'b0;
      next_cur.status[ST_TX_HALT] = 1'b1;
    end
    if (tx_cmd_start && cur.tx_st == TX_STOPPED && cur.tx_pos == ZERO_WORD) begin
      next_cur.tx_pos = cur.tx_base;
    end
    // Receive process
    case (cur.rx_st)
      RX_STOPPED: if (rx_cmd_start) next_cur.rx_st = RX_FETCH;
      RX_FETCH: begin
        if (rx_desc_done_i) begin
          if (!rx_desc_owned_i) begin
            next_cur.rx_st = RX_SUSPENDED;
            if (!cur.rx_unown_seen) next_cur.status[ST_RX_UNOWN] = 1'b1;
            next_cur.rx_unown_seen = 1'b1;
          end else begin
            next_cur.rx_st = RX_WAIT_FRAME;
            next_cur.rx_unown_seen = 1'b0;
          end
        end
      end
      RX_SUSPENDED: if (rx_frame_start_i) next_cur.rx_st = RX_FETCH;
      RX_WAIT_FRAME: if (rx_frame_start_i) next_cur.rx_st = RX_XFER;
      RX_XFER: begin
        next_cur.rx_buf = rx_buf_addr_i;
        if (rx_overlength_i) next_cur.status[ST_RX_OVERLEN] = 1'b1;
        if (rx_frame_end_i) next_cur.rx_st = RX_CLOSE;
      end
      RX_CLOSE: begin
        next_cur.rx_pos = cur.rx_pos + DESC_STEP;
        next_cur.status[ST_RX_DONE] = 1'b1;
        next_cur.rx_st = RX_FETCH;
      end
      default: next_cur.rx_st = RX_STOPPED;
    endcase
    // Receive stops only between frames and only with the MAC receiver off
    if (!cur.control[CTL_RX_RUN] && !mac_receiver_on_i &&
        (cur.rx_st == RX_FETCH || cur.rx_st == RX_SUSPENDED || cur.rx_st == RX_WAIT_FRAME)) begin
      next_cur.rx_st = RX_STOPPED;
      next_cur.status[ST_RX_HALT] = 1'b1;
    end
    if (rx_cmd_start && cur.rx_st == RX_STOPPED && cur.rx_pos == ZERO_WORD) begin
      next_cur.rx_pos = cur.rx_base;
    end
    if (rx_cmd_stop) next_cur.rx_unown_seen = 1'b0;
    // Software reset clears enables and control and puts both processes in Stopped
    if (soft_reset_i) begin
      next_cur.int_en = ZERO_WORD;
      next_cur.control = ZERO_WORD;
      next_cur.tx_st = TX_STOPPED;
      next_cur.rx_st = RX_STOPPED;
      next_cur.tx_pos = ZERO_WORD;
      next_cur.rx_pos = ZERO_WORD;
      next_cur.tx_pending = 1'b0;
      next_cur.rx_unown_seen = 1'b0;
      // A process cut off by the software reset still reports that it stopped
      if (cur.tx_st != TX_STOPPED) next_cur.status[ST_TX_HALT] = 1'b1;
      if (cur.rx_st != RX_STOPPED) next_cur.status[ST_RX_HALT] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs
  assign wb_ack_o = cur.ack;
  assign wb_dat_o = cur.rdata;
  assign tx_desc_addr_o = cur.tx_pos;
  assign rx_desc_addr_o = cur.rx_pos;
  assign tx_fetch_o = cur.tx_st == TX_FETCH;
  assign rx_fetch_o = cur.rx_st == RX_FETCH;
  assign second_frame_overlap_o = cur.control[CTL_OVERLAP];
  assign required_one_bit_o = cur.control[CTL_ONE];
  assign normal_irq_o = nrm_sum;
  assign abnormal_irq_o = abn_sum;

  // Checks
  // Entry into Stopped, seen as two consecutive samples of the process state
  sequence s_tx_enters_stop;
    cur.tx_st != TX_STOPPED ##1 cur.tx_st == TX_STOPPED;
  endsequence
  sequence s_rx_enters_stop;
    cur.rx_st != RX_STOPPED ##1 cur.rx_st == RX_STOPPED;
  endsequence
  // Reset is still sampled high at its release edge, so look one edge later
  a_int_en_reset: assert property (@(posedge clk_i)
    !rst_i && ($past(rst_i) || $past(soft_reset_i)) |-> cur.int_en == ZERO_WORD)
    else $error("enables not cleared by reset");
  a_tx_start_run: assert property (@(posedge clk_i) disable iff (rst_i || soft_reset_i)
    cur.tx_st == TX_STOPPED && wr && adr == ADDR_CONTROL && !soft_reset_i && wb_dat_i[CTL_TX_RUN]
    && wb_sel_i[1] && !cur.control[CTL_TX_RUN] |=> cur.tx_st == TX_FETCH)
    else $error("transmit did not start");
  a_tx_unowned: assert property (@(posedge clk_i) disable iff (rst_i || soft_reset_i)
    cur.tx_st == TX_FETCH && tx_desc_done_i && !tx_desc_owned_i && !cur.tx_pending && !soft_reset_i
    |=> cur.tx_st == TX_SUSPENDED && cur.status[ST_TX_UNOWN]) else $error("transmit unowned not handled");
  a_tx_halt_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    s_tx_enters_stop |-> cur.status[ST_TX_HALT]) else $error("transmit halt flag missing");
  a_rx_halt_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rx_enters_stop |-> cur.status[ST_RX_HALT]) else $error("receive halt flag missing");
  a_rx_keep_run: assert property (@(posedge clk_i) disable iff (rst_i || soft_reset_i)
    mac_receiver_on_i && !soft_reset_i && cur.rx_st != RX_STOPPED |=> cur.rx_st != RX_STOPPED)
    else $error("receive stopped with MAC on");
  a_nrm_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !cur.int_en[ST_NRM_SUM] |-> !normal_irq_o) else $error("normal irq without gate");
  a_abn_rx_done: assert property (@(posedge clk_i) disable iff (rst_i)
    cur.status[ST_RX_DONE] && cur.int_en[ST_RX_DONE] && cur.int_en[ST_ABN_SUM] |-> abnormal_irq_o)
    else $error("receive done not on abnormal");
  a_miss_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && adr == ADDR_MISSED && !fifo_full_drop_i && !no_buffer_drop_i
    |=> cur.full_cnt == 11'h0 && cur.nobuf_cnt == 16'h0) else $error("counters not cleared on read");
endmodule

// ### tb/ddr_mem_model.sv
// Far-side model: descriptor fetch engine answering fetch requests from host memory.
// Assumes fetch levels from the run-control block; the bench picks ownership and delay.
`timescale 1ns/100ps
module ddr_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] delay_i,
  input wire logic tx_fetch_i,
  input wire logic rx_fetch_i,
  input wire logic tx_own_i,
  input wire logic rx_own_i,
  output logic tx_done_o,
  output logic tx_owned_o,
  output logic rx_done_o,
  output logic rx_owned_o
);
  logic [3:0] tx_cnt;
  logic [3:0] rx_cnt;
  // Answer after delay_i cycles; owned toggles outside done so no stale value is trusted
  always_ff @(posedge clk_i) begin
    tx_owned_o <= ~tx_owned_o;
    rx_owned_o <= ~rx_owned_o;
    tx_done_o <= 1'h0;
    rx_done_o <= 1'h0;
    tx_cnt <= tx_fetch_i ? tx_cnt + 4'h1 : 4'h0;
    rx_cnt <= rx_fetch_i ? rx_cnt + 4'h1 : 4'h0;
    if (tx_fetch_i && !tx_done_o && tx_cnt >= delay_i) begin
      tx_done_o <= 1'h1;
      tx_owned_o <= tx_own_i;
      tx_cnt <= 4'h0;
    end
    if (rx_fetch_i && !rx_done_o && rx_cnt >= delay_i) begin
      rx_done_o <= 1'h1;
      rx_owned_o <= rx_own_i;
      rx_cnt <= 4'h0;
    end
    if (rst_i) begin
      tx_cnt <= 4'h0;
      rx_cnt <= 4'h0;
      tx_done_o <= 1'h0;
      rx_done_o <= 1'h0;
    end
  end
endmodule

// ### tb/ddr_run_control_tb.sv
// Self-checking bench for the descriptor DMA run-control block.
// Assumes ddr_mem_model answers descriptor fetches; this module is the Wishbone master.
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR %0t: got %h want %h", $time, (a), (e)); end end
module ddr_run_control_tb;
  import ddr_pkg::*;
  localparam logic [31:0] TXB = 32'h0000_1000;
  localparam logic [31:0] RXB = 32'h0000_2000;
  localparam logic [31:0] TBUF = 32'h0000_4000;
  localparam logic [31:0] RBUF = 32'h0000_6000;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic soft_rst = 1'h0;
  logic [31:0] adr = 32'h0, wdat = 32'h0, tx_buf = 32'h0, rx_buf = 32'h0, rdat, tx_desc, rx_desc;
  logic we = 1'h0, cyc = 1'h0, stb = 1'h0, mac_on = 1'h0, tx_dd = 1'h0, tx_sd = 1'h0;
  logic rx_fs = 1'h0, rx_fe = 1'h0, rx_ovl = 1'h0, fifo_drop = 1'h0, nobuf_drop = 1'h0;
  logic tx_own = 1'h0, rx_own = 1'h0, ack, tx_fetch, rx_fetch, second_frame_overlap, one_bit, nirq, airq;
  logic tx_dn, tx_ow, rx_dn, rx_ow;
  logic [3:0] sel = 4'hf, delay = 4'h2;
  int err_count = 0;
  int check_count = 0;
  // Half-period toggle gives 50 MHz
  always #10 clk_i = ~clk_i;
  ddr_run_control ddr_run_control_inst (.clk_i(clk_i), .rst_i(rst_i), .soft_reset_i(soft_rst),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .mac_receiver_on_i(mac_on), .tx_desc_done_i(tx_dn),
    .tx_desc_owned_i(tx_ow), .tx_data_done_i(tx_dd), .tx_status_done_i(tx_sd), .tx_buf_addr_i(tx_buf),
    .rx_desc_done_i(rx_dn), .rx_desc_owned_i(rx_ow), .rx_frame_start_i(rx_fs), .rx_frame_end_i(rx_fe),
    .rx_buf_addr_i(rx_buf), .rx_overlength_i(rx_ovl), .fifo_full_drop_i(fifo_drop),
    .no_buffer_drop_i(nobuf_drop), .tx_desc_addr_o(tx_desc), .rx_desc_addr_o(rx_desc),
    .tx_fetch_o(tx_fetch), .rx_fetch_o(rx_fetch), .second_frame_overlap_o(second_frame_overlap),
    .required_one_bit_o(one_bit), .normal_irq_o(nirq), .abnormal_irq_o(airq));
  ddr_mem_model ddr_mem_model_inst (.clk_i(clk_i), .rst_i(rst_i), .delay_i(delay), .tx_fetch_i(tx_fetch),
    .rx_fetch_i(rx_fetch), .tx_own_i(tx_own), .rx_own_i(rx_own), .tx_done_o(tx_dn), .tx_owned_o(tx_ow),
    .rx_done_o(rx_dn), .rx_owned_o(rx_ow));
  task automatic report_and_stop;
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One classic cycle; held until ack is sampled, bounded so a dead slave cannot hang us
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= {24'h0, a};
    we <= w;
    wdat <= d;
    cyc <= 1'h1;
    stb <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 40);
    if (ack !== 1'h1) begin
      err_count++;
      $display("ERROR %0t: no ack", $time);
    end
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'h1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(a, 1'h0, 32'h0, q);
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v, output logic [31:0] s);
    int n;
    n = 0;
    do begin
      rd(ADDR_STATUS, s);
      n++;
    end while ((s & m) !== v && n < 30);
  endtask
  task automatic wait_fetch;
    int n;
    n = 0;
    while (tx_fetch !== 1'h1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(tx_fetch, 1'h1)
  endtask
  // Control word always keeps the required one bit set
  function automatic logic [31:0] cw(input logic t, input logic r);
    cw = ZERO_WORD;
    cw[CTL_ONE] = 1'h1;
    cw[CTL_TX_RUN] = t;
    cw[CTL_RX_RUN] = r;
  endfunction
  task automatic t_reset;
    logic [31:0] s;
    rd(ADDR_INT_EN, s);
    `CHK(s, ZERO_WORD)
    rd(ADDR_MISSED, s);
    `CHK(s, ZERO_WORD)
    wr(ADDR_TX_BUF, 32'hffff_ffff);
    rd(ADDR_TX_BUF, s);
    `CHK(s, ZERO_WORD)
    rd(ADDR_RX_BUF, s);
    `CHK(s, ZERO_WORD)
    wr(ADDR_CONTROL, cw(1'h0, 1'h0) | 32'h4);
    @(posedge clk_i);
    `CHK({second_frame_overlap, one_bit}, 2'h3)
  endtask
  task automatic t_tx_suspend;
    logic [31:0] s;
    wr(ADDR_TX_BASE, TXB);
    wr(ADDR_CONTROL, cw(1'h1, 1'h0));
    poll(32'h0070_0004, 32'h0060_0004, s);
    `CHK(s & 32'h0070_0004, 32'h0060_0004)
    wr(ADDR_CONTROL, cw(1'h1, 1'h0));
    rd(ADDR_STATUS, s);
    `CHK(s[22:20], TX_SUSPENDED)
    wr(ADDR_INT_EN, 32'h0000_0004);
    @(posedge clk_i);
    `CHK(nirq, 1'h0)
    wr(ADDR_INT_EN, 32'h0001_0004);
    @(posedge clk_i);
    `CHK(nirq, 1'h1)
    wr(ADDR_CONTROL, cw(1'h0, 1'h0));
    poll(32'h0070_0002, 32'h0000_0002, s);
    `CHK(s & 32'h0070_0002, 32'h0000_0002)
    wr(ADDR_INT_EN, 32'h0000_0002);
    @(posedge clk_i);
    `CHK(airq, 1'h0)
    wr(ADDR_INT_EN, 32'hffff_ffff);
    @(posedge clk_i);
    `CHK(airq, 1'h1)
    rd(ADDR_INT_EN, s);
    `CHK(s, INT_EN_MASK)
    @(posedge clk_i) soft_rst <= 1'h1;
    @(posedge clk_i) soft_rst <= 1'h0;
    rd(ADDR_INT_EN, s);
    `CHK(s, ZERO_WORD)
  endtask
  // Owned frame, next descriptor, then stop and resume from the saved position
  task automatic t_tx_run;
    logic [31:0] s;
    wr(ADDR_STATUS, 32'hffff_ffff);
    tx_own <= 1'h1;
    tx_buf <= TBUF;
    wr(ADDR_TX_BASE, TXB);
    wr(ADDR_CONTROL, cw(1'h1, 1'h0));
    wait_fetch;
    `CHK(tx_desc, TXB)
    poll(32'h0070_0000, 32'h0030_0000, s);
    `CHK(s[22:20], TX_READ_DATA)
    @(posedge clk_i) tx_dd <= 1'h1;
    @(posedge clk_i) tx_dd <= 1'h0;
    @(posedge clk_i) tx_sd <= 1'h1;
    @(posedge clk_i) tx_sd <= 1'h0;
    tx_own <= 1'h0;
    wait_fetch;
    `CHK(tx_desc, TXB + DESC_STEP)
    rd(ADDR_TX_BUF, s);
    `CHK(s, TBUF)
    poll(32'h0070_0000, 32'h0060_0000, s);
    wr(ADDR_CONTROL, cw(1'h0, 1'h0));
    poll(32'h0070_0000, 32'h0, s);
    `CHK(s[22:20], TX_STOPPED)
    // Resume on an owned descriptor with second-frame overlap: no wait for frame status
    tx_own <= 1'h1;
    wr(ADDR_CONTROL, cw(1'h1, 1'h0) | (32'h1 << CTL_OVERLAP));
    wait_fetch;
    `CHK(tx_desc, TXB + DESC_STEP)
    poll(32'h0070_0000, 32'h0030_0000, s);
    @(posedge clk_i) tx_dd <= 1'h1;
    @(posedge clk_i) tx_dd <= 1'h0;
    tx_own <= 1'h0;
    repeat (2) @(posedge clk_i);
    `CHK(tx_fetch, 1'h1)
    `CHK(tx_desc, TXB + DESC_STEP + DESC_STEP)
    wr(ADDR_CONTROL, cw(1'h0, 1'h0));
  endtask
  // Owned receive frame: buffer pointer, saved position and receive done on the abnormal gate
  task automatic t_rx_frame;
    logic [31:0] s;
    rx_own <= 1'h1;
    rx_buf <= RBUF;
    wr(ADDR_STATUS, 32'hffff_ffff);
    wr(ADDR_CONTROL, cw(1'h0, 1'h1));
    poll(32'h000e_0000, 32'h0006_0000, s);
    `CHK(s & 32'h000e_0000, 32'h0006_0000)
    @(posedge clk_i) rx_fs <= 1'h1;
    @(posedge clk_i) rx_fs <= 1'h0;
    @(posedge clk_i) rx_fe <= 1'h1;
    @(posedge clk_i) rx_fe <= 1'h0;
    rd(ADDR_RX_BUF, s);
    `CHK(s, RBUF)
    `CHK(rx_desc, RXB + DESC_STEP)
    wr(ADDR_INT_EN, 32'h0001_0040);
    @(posedge clk_i);
    `CHK({nirq, airq}, 2'h0)
    wr(ADDR_INT_EN, 32'h0000_8040);
    @(posedge clk_i);
    `CHK(airq, 1'h1)
    wr(ADDR_CONTROL, cw(1'h0, 1'h0));
  endtask
  task automatic t_rx;
    logic [31:0] s;
    wr(ADDR_INT_EN, 32'h0);
    wr(ADDR_STATUS, 32'hffff_ffff);
    wr(ADDR_RX_BASE, RXB);
    wr(ADDR_CONTROL, cw(1'h0, 1'h1));
    poll(32'h000e_0080, 32'h0008_0080, s);
    `CHK(s & 32'h000e_0080, 32'h0008_0080)
    `CHK(rx_desc, RXB)
    mac_on <= 1'h1;
    wr(ADDR_CONTROL, cw(1'h0, 1'h0));
    repeat (5) @(posedge clk_i);
    rd(ADDR_STATUS, s);
    `CHK(s & 32'h000e_0100, 32'h0008_0000)
    mac_on <= 1'h0;
    wr(ADDR_CONTROL, cw(1'h0, 1'h0));
    poll(32'h000e_0100, 32'h0000_0100, s);
    `CHK(s & 32'h000e_0100, 32'h0000_0100)
    wr(ADDR_INT_EN, 32'h0000_0380);
    @(posedge clk_i);
    `CHK(airq, 1'h0)
    wr(ADDR_INT_EN, 32'h0000_8100);
    @(posedge clk_i);
    `CHK(airq, 1'h1)
  endtask
  // Small counts first, then a run long enough to wrap both counters
  task automatic t_count;
    logic [31:0] s;
    @(posedge clk_i);
    fifo_drop <= 1'h1;
    nobuf_drop <= 1'h1;
    repeat (2) @(posedge clk_i);
    nobuf_drop <= 1'h0;
    @(posedge clk_i);
    fifo_drop <= 1'h0;
    rd(ADDR_MISSED, s);
    `CHK(s, 32'h0006_0002)
    rd(ADDR_MISSED, s);
    `CHK(s, ZERO_WORD)
    @(posedge clk_i);
    fifo_drop <= 1'h1;
    nobuf_drop <= 1'h1;
    repeat (65537) @(posedge clk_i);
    fifo_drop <= 1'h0;
    nobuf_drop <= 1'h0;
    rd(ADDR_MISSED, s);
    `CHK(s, 32'h1003_0001)
    rd(ADDR_MISSED, s);
    `CHK(s, ZERO_WORD)
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset;
    t_tx_suspend;
    t_tx_run;
    t_rx;
    t_rx_frame;
    t_count;
    report_and_stop;
  end
  // Whole run needs about 70k cycles; the limit keeps a hang under 100k
  initial begin
    repeat (90000) @(posedge clk_i);
    err_count++;
    $display("ERROR %0t: timeout", $time);
    report_and_stop;
  end
endmodule
